// file: include/slss_pkg.sv
// constants for the lane sync status block
package slss_pkg;
  localparam int LANES     = 8;
  localparam int ERR_LANES = 3;
  localparam int LINKS     = 2;
  localparam int CNT_W     = 8;
  localparam int IDX_W     = 11;
  localparam int AW        = 13;
  localparam int DW        = 32;
  localparam int INT_W     = 22;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] LINK_PAGE_IDX = 11'h0300;
  localparam logic [IDX_W-1:0] ERR_FLAGS_IDX = 11'h046f;
  localparam logic [IDX_W-1:0] LOCK_IDX      = 11'h0470;
  localparam logic [IDX_W-1:0] THRESH_IDX    = 11'h047c;
  localparam logic [IDX_W-1:0] INT_STAT_IDX  = 11'h047d;
  localparam logic [IDX_W-1:0] INT_MASK_IDX  = 11'h047e;
  localparam logic [IDX_W-1:0] CNT_CLR_IDX   = 11'h047f;

  // reset values and counter saturation limit
  localparam logic             PAGE_RST   = 1'b0;
  localparam logic [CNT_W-1:0] THRESH_RST = 8'hff;
  localparam logic [CNT_W-1:0] CNT_RST    = 8'h00;
  localparam logic [CNT_W-1:0] CNT_MAX    = 8'hff;
  localparam logic [INT_W-1:0] INT_RST    = 22'h00_0000;

  // interrupt field positions
  localparam int INT_LOST_LSB = 0;
  localparam int INT_ERR_LSB  = 16;
endpackage

// file: core/slss_err_counter.sv
// per-lane saturating control character error counter
`timescale 1ns/1ps
module slss_err_counter (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        err_pulse,
  input  wire logic                        clr_pulse,
  input  wire logic [slss_pkg::CNT_W-1:0]  threshold,
  output logic      [slss_pkg::CNT_W-1:0]  count,
  output logic                             flag
);
  logic [slss_pkg::CNT_W-1:0] count_reg;
  logic [slss_pkg::CNT_W-1:0] count_next;
  logic [slss_pkg::CNT_W-1:0] base;
  logic                       at_max;

  assign base   = clr_pulse ? slss_pkg::CNT_RST : count_reg;
  assign at_max = (base == slss_pkg::CNT_MAX);

  assign count_next = (err_pulse && !at_max) ? base + 8'h01 : base;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_reg <= slss_pkg::CNT_RST;
    else
      count_reg <= count_next;
  end

  assign count = count_reg;
  assign flag  = (count_reg >= threshold);
endmodule

// file: core/slss_top.sv
// lane code group lock and control char error status with apb registers
`timescale 1ns/1ps
module slss_top (
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [slss_pkg::AW-1:0]        paddr,
  input  wire logic [slss_pkg::DW-1:0]        pwdata,
  output logic      [slss_pkg::DW-1:0]        prdata,
  output logic                                pready,
  output logic                                pslverr,
  output logic                                irq,
  input  wire logic [slss_pkg::LANES-1:0]     rx_lock_link0,
  input  wire logic [slss_pkg::LANES-1:0]     rx_lock_link1,
  input  wire logic [slss_pkg::ERR_LANES-1:0] rx_ctrl_char_err_link0,
  input  wire logic [slss_pkg::ERR_LANES-1:0] rx_ctrl_char_err_link1
);
  localparam int LANES = slss_pkg::LANES;
  localparam int ELN   = slss_pkg::ERR_LANES;
  localparam int LINKS = slss_pkg::LINKS;
  localparam int CW    = slss_pkg::CNT_W;
  localparam int IW    = slss_pkg::INT_W;

  // register state
  logic                 page_reg;
  logic [CW-1:0]        thresh_reg;
  logic [IW-1:0]        int_stat_reg;
  logic [IW-1:0]        int_stat_next;
  logic [IW-1:0]        int_mask_reg;
  logic [31:0]          prdata_reg;
  logic [31:0]          prdata_next;
  logic                 rd_load;
  logic                 irq_reg;
  logic                 irq_next;
  logic                 page_wr;
  logic                 thresh_wr;
  logic                 mask_wr;
  logic [LANES-1:0]     lock_prev_reg [LINKS];
  logic [ELN-1:0]       flag_prev_reg [LINKS];

  // per-link views
  logic [LANES-1:0]     lock_in [LINKS];
  logic [ELN-1:0]       err_in  [LINKS];
  logic [ELN-1:0]       flag    [LINKS];
  logic [ELN-1:0]       clr     [LINKS];
  logic [LANES-1:0]     lock_lost [LINKS];
  logic [ELN-1:0]       flag_rise [LINKS];

  assign lock_in[0] = rx_lock_link0;
  assign lock_in[1] = rx_lock_link1;
  assign err_in[0]  = rx_ctrl_char_err_link0;
  assign err_in[1]  = rx_ctrl_char_err_link1;

  // apb decode
  logic [slss_pkg::IDX_W-1:0] idx;
  logic                       setup;
  logic                       access;
  logic                       wr_en;
  logic                       hit_page;
  logic                       hit_flags;
  logic                       hit_lock;
  logic                       hit_thresh;
  logic                       hit_stat;
  logic                       hit_mask;
  logic                       hit_clr;
  logic                       addr_hit;
  logic                       ro_hit;

  assign idx        = paddr[slss_pkg::AW-1:2];
  assign setup      = psel && !penable;
  assign access     = psel && penable;
  assign hit_page   = (idx == slss_pkg::LINK_PAGE_IDX);
  assign hit_flags  = (idx == slss_pkg::ERR_FLAGS_IDX);
  assign hit_lock   = (idx == slss_pkg::LOCK_IDX);
  assign hit_thresh = (idx == slss_pkg::THRESH_IDX);
  assign hit_stat   = (idx == slss_pkg::INT_STAT_IDX);
  assign hit_mask   = (idx == slss_pkg::INT_MASK_IDX);
  assign hit_clr    = (idx == slss_pkg::CNT_CLR_IDX);
  assign ro_hit     = hit_flags || hit_lock;
  assign addr_hit   = (paddr[1:0] == 2'b00) &&
                      (hit_page || ro_hit || hit_thresh || hit_stat || hit_mask || hit_clr);
  assign wr_en      = access && pwrite && addr_hit && !ro_hit;

  assign pready  = access;
  assign pslverr = access && (!addr_hit || (pwrite && ro_hit));

  // counters, flags and edge detection per link and lane
  genvar gl;
  genvar gn;
  generate
    for (gl = 0; gl < LINKS; gl++)
    begin : g_link
      for (gn = 0; gn < ELN; gn++)
      begin : g_lane
        assign clr[gl][gn] = wr_en && hit_clr && pwdata[gn] && (page_reg == 1'(gl));
        slss_err_counter u_cnt (
          .pclk      (pclk),
          .presetn   (presetn),
          .err_pulse (err_in[gl][gn]),
          .clr_pulse (clr[gl][gn]),
          .threshold (thresh_reg),
          .count     (),
          .flag      (flag[gl][gn])
        );
      end
      assign lock_lost[gl] = lock_prev_reg[gl] & ~lock_in[gl];
      assign flag_rise[gl] = flag[gl] & ~flag_prev_reg[gl];

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          lock_prev_reg[gl] <= '0;
          flag_prev_reg[gl] <= '0;
        end
        else
        begin
          lock_prev_reg[gl] <= lock_in[gl];
          flag_prev_reg[gl] <= flag[gl];
        end
      end
    end
  endgenerate

  // paged status views
  logic [LANES-1:0] lock_sel;
  logic [ELN-1:0]   flag_sel;
  logic [7:0]       flags_byte;
  logic [IW-1:0]    int_events;
  logic [IW-1:0]    int_clear;

  assign lock_sel   = page_reg ? lock_in[1] : lock_in[0];
  assign flag_sel   = page_reg ? flag[1] : flag[0];
  assign flags_byte = {5'h00, flag_sel};

  assign int_events = {flag_rise[1], flag_rise[0], lock_lost[1], lock_lost[0]};
  assign int_clear  = (wr_en && hit_stat) ? pwdata[IW-1:0] : '0;
  // set wins over write-one clear
  assign int_stat_next = (int_stat_reg & ~int_clear) | int_events;

  // read mux
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit_page)
      rd_mux = {31'h0000_0000, page_reg};
    else if (hit_flags)
      rd_mux = {24'h00_0000, flags_byte};
    // lock bit n is lane n
    else if (hit_lock)
      rd_mux = {24'h00_0000, lock_sel};
    else if (hit_thresh)
      rd_mux = {24'h00_0000, thresh_reg};
    else if (hit_stat)
      rd_mux = {10'h000, int_stat_reg};
    else if (hit_mask)
      rd_mux = {10'h000, int_mask_reg};
  end

  // control register write strobes
  assign page_wr   = wr_en && hit_page;
  assign thresh_wr = wr_en && hit_thresh;
  assign mask_wr   = wr_en && hit_mask;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      page_reg <= slss_pkg::PAGE_RST;
    else if (page_wr)
      page_reg <= pwdata[0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      thresh_reg <= slss_pkg::THRESH_RST;
    else if (thresh_wr)
      thresh_reg <= pwdata[CW-1:0];
  end

  // interrupt mask
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_mask_reg <= slss_pkg::INT_RST;
    else if (mask_wr)
      int_mask_reg <= pwdata[IW-1:0];
  end

  // sticky status
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_stat_reg <= slss_pkg::INT_RST;
    else
      int_stat_reg <= int_stat_next;
  end

  // level interrupt from unmasked status
  assign irq_next = |(int_stat_next & int_mask_reg);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_reg <= 1'b0;
    else
      irq_reg <= irq_next;
  end

  // read data captured in setup, bad address reads 0
  assign rd_load     = setup && !pwrite;
  assign prdata_next = addr_hit ? rd_mux : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_reg <= 32'h0000_0000;
    else if (rd_load)
      prdata_reg <= prdata_next;
  end

  assign prdata = prdata_reg;
  assign irq    = irq_reg;
endmodule

// file: verif/slss_lane_src.sv
// behavioural transmitter lanes: lock levels and error pulses
`timescale 1ns/1ps
module slss_lane_src (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] lock_req0,
  input  wire logic [7:0] lock_req1,
  input  wire logic [5:0] err_req,
  output logic      [7:0] rx_lock_link0,
  output logic      [7:0] rx_lock_link1,
  output logic      [5:0] err_out
);
  // lanes unlocked until reset ends; err_out[2:0] link 0, [5:3] link 1
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      {rx_lock_link0, rx_lock_link1, err_out} <= '0;
    else
      {rx_lock_link0, rx_lock_link1, err_out} <= {lock_req0, lock_req1, err_req};
endmodule

// file: verif/slss_top_chk.sv
// port assertions for the lane sync status block
`timescale 1ns/1ps
module slss_top_chk (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [slss_pkg::AW-1:0]    paddr,
  input wire logic [slss_pkg::DW-1:0]    prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire logic [slss_pkg::LANES-1:0] rx_lock_link0,
  input wire logic [slss_pkg::LANES-1:0] rx_lock_link1
);
  localparam logic [12:0] A_EF = {slss_pkg::ERR_FLAGS_IDX, 2'b00};
  localparam logic [12:0] A_LK = {slss_pkg::LOCK_IDX, 2'b00};
  localparam logic [12:0] A_CL = {slss_pkg::CNT_CLR_IDX, 2'b00};
  wire rd_su = psel && !penable && !pwrite;
  wire acc   = psel && penable;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_access: assert property (pready == acc) else $error("pready outside access");
  a_idle_quiet: assert property (!psel |-> !pslverr) else $error("pslverr while idle");
  a_lock_read: assert property (rd_su && paddr == A_LK && rx_lock_link0 == rx_lock_link1
    |=> prdata == {24'h00_0000, $past(rx_lock_link0)}) else $error("lock status read wrong");
  a_flag_upper: assert property (rd_su && paddr == A_EF |=> prdata[31:3] == '0)
    else $error("flag register upper bits set");
  a_ro_refuse: assert property (acc && pwrite && (paddr == A_EF || paddr == A_LK) |-> pslverr)
    else $error("status write not refused");
  a_read_hold: assert property (!rd_su |=> $stable(prdata)) else $error("read data moved");
  a_clr_reads0: assert property (rd_su && paddr == A_CL |=> prdata == '0) else $error("clear reg not 0");
  a_misalign_refused: assert property (acc && paddr[1:0] != 2'b00 |-> pslverr) else $error("misaligned accepted");
endmodule
bind slss_top slss_top_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
  .pready, .pslverr, .rx_lock_link0, .rx_lock_link1);

// file: verif/testbench.sv
// self-checking bench for the lane sync status block
`timescale 1ns/1ps
module testbench;
  localparam logic [12:0] A_PG = {slss_pkg::LINK_PAGE_IDX, 2'b00};
  localparam logic [12:0] A_EF = {slss_pkg::ERR_FLAGS_IDX, 2'b00};
  localparam logic [12:0] A_LK = {slss_pkg::LOCK_IDX, 2'b00};
  localparam logic [12:0] A_TH = {slss_pkg::THRESH_IDX, 2'b00};
  localparam logic [12:0] A_ST = {slss_pkg::INT_STAT_IDX, 2'b00};
  localparam logic [12:0] A_MK = {slss_pkg::INT_MASK_IDX, 2'b00};
  localparam logic [12:0] A_CL = {slss_pkg::CNT_CLR_IDX, 2'b00};
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, er;
  logic [12:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, seed = 32'h0000_d163;
  logic [7:0]  lr0 = '0, lr1 = '0, rx_lock_link0, rx_lock_link1, th, cnt [6];
  logic [5:0]  err_req = '0, err_out;
  logic [12:0] ra [11] = '{A_TH, A_MK, A_ST, A_PG, A_LK, A_EF, A_CL, A_LK, A_EF, 13'h0004, 13'h0c01};
  int          num_errors = 0, n_compared = 0, cyc = 0;
  slss_lane_src u_src (.pclk, .presetn, .lock_req0(lr0), .lock_req1(lr1), .err_req, .rx_lock_link0,
    .rx_lock_link1, .err_out);
  slss_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .irq, .rx_lock_link0, .rx_lock_link1, .rx_ctrl_char_err_link0(err_out[2:0]),
    .rx_ctrl_char_err_link1(err_out[5:3]));
  function automatic void xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
  endfunction
  function automatic logic [2:0] flags(input logic [23:0] c, input logic [7:0] t);
    for (int i = 0; i < 3; i++)
      flags[i] = c[8*i +: 8] >= t;
  endfunction
  task automatic chk_rd(input logic [31:0] exp);
    n_compared++;
    if (rd !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t read %h exp %h", $time, rd, exp);
    end
  endtask
  task automatic chk_err(input logic exp);
    n_compared++;
    if (er !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t pslverr %b exp %b", $time, er, exp);
    end
  endtask
  task automatic chk_irq(input logic exp);
    n_compared++;
    if (irq !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t irq %b exp %b", $time, irq, exp);
    end
  endtask
  task automatic flag_pages();
    for (int p = 0; p < 2; p++)
    begin
      apb(1, A_PG, p);
      apb(0, A_EF, 0);
      chk_rd(flags({cnt[3*p+2], cnt[3*p+1], cnt[3*p]}, th));
    end
  endtask
  task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic pulse(input int idx, input logic [7:0] n);
    repeat (n)
    begin
      @(posedge pclk);
      err_req[idx] <= 1;
      @(posedge pclk);
      err_req[idx] <= 0;
    end
    repeat (3) @(posedge pclk);
  endtask
  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask
  task automatic end_of_test();
    $display("errors %0d compares %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always #10 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      $display("[ERR] %0t timeout", $time);
      end_of_test();
    end
  end
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    foreach (ra[i])
    begin
      apb(0, ra[i], 0);
      chk_rd(i == 0 ? {24'h00_0000, slss_pkg::THRESH_RST} : 32'h0000_0000);
      chk_err(i > 8);
      if (i > 6)
      begin
        apb(1, ra[i], '1);
        chk_err(1'b1);
      end
    end
    apb(0, A_PG, 0);
    chk_rd(32'h0000_0000);
    for (int k = 0; k < 4; k++)
    begin
      xs();
      lr0 <= seed[7:0];
      // last round: equal links
      lr1 <= (k == 3) ? seed[7:0] : seed[15:8];
      for (int p = 0; p < 2; p++)
      begin
        apb(1, A_PG, p);
        apb(0, A_LK, 0);
        chk_rd(p ? lr1 : lr0);
      end
    end
    xs();
    th = seed[1:0] + 8'd1;
    apb(1, A_TH, th);
    apb(0, A_TH, 0);
    chk_rd(th);
    for (int i = 0; i < 6; i++)
    begin
      xs();
      cnt[i] = 8'(seed[2:0] % 6);
      pulse(i, cnt[i]);
    end
    flag_pages();
    th = cnt[3];
    apb(1, A_TH, th);
    apb(1, A_CL, 2);
    cnt[4] = 0;
    flag_pages();
    lr0 <= 8'hff;
    settle();
    apb(1, A_ST, 32'h003f_ffff);
    apb(1, A_MK, 1);
    settle();
    chk_irq(1'b0);
    @(posedge pclk);
    lr0 <= 8'hfe;
    settle();
    settle();
    chk_irq(1'b1);
    apb(0, A_ST, 0);
    chk_rd(32'h0000_0001 << slss_pkg::INT_LOST_LSB);
    apb(1, A_MK, 0);
    settle();
    chk_irq(1'b0);
    apb(1, A_MK, 1);
    apb(1, A_ST, 1);
    settle();
    chk_irq(1'b0);
    apb(0, A_ST, 0);
    chk_rd(32'h0000_0000);
    end_of_test();
  end
endmodule
